// File: verilog/vpic_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "vpic_regs.svh"

// Summary of operation
// - Three-bit priority per source; 7 highest, 1 lowest, 0 disables the source.
// - Source priority sits at bits 6:4; all other bits read zero.
// - Every source priority resets to level 4.
// - Deliver only when source level exceeds the CPU level; others wait.
// - Test bit 15 shows a request held off by an equal or higher CPU level.
// - Test bit 13 selects pending or last acknowledged vector for readback.
// - Test bits 6:0 give the vector number, 0 to 118.
// - Test bits 11:8 give the current CPU priority level.
// - Control-one bit 15 set forbids nesting of user interrupts.
// - A source requests only while its enable bit is set.
// - Source flags stay set until software clears them; request persists.
// - Return from interrupt restores the previous CPU level.
// - Trap flags stay set until software clears them.
// - Status byte level 7 masks all user interrupts; restore unmasks.
// - Traps sit at levels 8 to 11; status byte and timed disable never mask them, but an equal or higher CPU level holds them.
// - Timed disable blocks levels 1 to 6 only, for a set period.
module vpic_ctrl
  import vpic_pkg::*;
#(
  parameter int NSRC  = 16,
  parameter int NTRAP = 4,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Register bus
  input  wire vpic_apb_req_s apb_req,
  output var  vpic_apb_rsp_s apb_rsp,
  // Event sources
  input  wire logic [NSRC-1:0]  src_evt,
  input  wire logic [NTRAP-1:0] trap_evt,
  // Processor side
  input  wire vpic_cpu_cmd_s cpu_cmd,
  output var  vpic_cpu_irq_s cpu_irq,
  output var  logic [3:0]    cpu_level,
  // Block interrupt
  output var  logic          irq_o
);

  localparam int SPW = $clog2(DEPTH + 1);
  localparam int SIW = (NSRC > 1) ? $clog2(NSRC) : 1;

  typedef struct packed {
    logic [NSRC-1:0][2:0]  prio;
    logic [NSRC-1:0]       flag;
    logic [NSRC-1:0]       en;
    logic [NTRAP-1:0]      trap;
    logic                  nesting_disable;
    logic                  vsel;
    logic [3:0]            cpu_lvl;
    logic [DEPTH-1:0][3:0] stk;
    logic [SPW-1:0]        sp;
    logic [13:0]           timed_interrupt_disable;
    logic [6:0]            last_vec;
    logic [2:0]            ist;
    logic [2:0]            imask;
    logic                  irq_out;
    logic                  unack;
    vpic_cpu_irq_s         irq;
    vpic_apb_rsp_s         rsp;
  } vpic_state_s;

  vpic_state_s st_r;
  vpic_state_s st_nxt;

  logic [3:0]  best_lvl;
  logic [6:0]  best_vec;
  logic        best_user;
  logic        deliver;
  logic        setup;
  logic        access;
  logic        hit;
  logic [15:0] rword;
  logic [2:0]  evt;

  function automatic logic in_prio(input logic [11:0] a);
    return a >= `VPIC_OFF_PRIO_BASE &&
           a < `VPIC_OFF_PRIO_BASE + 12'(4 * NSRC) && a[1:0] == 2'b00;
  endfunction : in_prio

  function automatic logic [SIW-1:0] prio_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - `VPIC_OFF_PRIO_BASE;
    return d[SIW+1:2];
  endfunction : prio_idx

  function automatic logic mapped(input logic [11:0] a);
    case (a)
      `VPIC_OFF_CTL1, `VPIC_OFF_TEST, `VPIC_OFF_FLAGS, `VPIC_OFF_ENABLE,
      `VPIC_OFF_IRQ_STAT, `VPIC_OFF_IRQ_MASK: return 1'b1;
      default: return in_prio(a);
    endcase
  endfunction : mapped

  always_comb begin
    st_nxt    = st_r;
    best_lvl  = 4'h0;
    best_vec  = 7'h00;
    best_user = 1'b0;
    evt       = 3'b000;
    rword     = 16'h0000;

    // Traps always compete, whatever the CPU level or timed disable
    for (int t = 0; t < NTRAP; t++) begin
      if (st_r.trap[t] && (`VPIC_LVL_TRAP_BASE + 4'(t)) > best_lvl) begin
        best_lvl = `VPIC_LVL_TRAP_BASE + 4'(t);
        best_vec = 7'(t);
      end
    end
    // Ascending scan with strict compare keeps the lowest vector on a tie
    for (int i = 0; i < NSRC; i++) begin
      if (st_r.flag[i] && st_r.en[i] && st_r.prio[i] != `VPIC_PRIO_OFF &&
          !(st_r.timed_interrupt_disable != 14'h0000 &&
            {1'b0, st_r.prio[i]} <= `VPIC_LVL_TIMED_INTERRUPT_DISABLE_MAX) &&
          {1'b0, st_r.prio[i]} > best_lvl) begin
        best_lvl  = {1'b0, st_r.prio[i]};
        best_vec  = `VPIC_VEC_USER_BASE + 7'(i);
        best_user = 1'b1;
      end
    end

    deliver = best_lvl > st_r.cpu_lvl &&
              !(best_user && st_r.nesting_disable && st_r.sp != '0);
    st_nxt.irq.req = deliver;
    st_nxt.irq.lvl = best_lvl;
    st_nxt.irq.vec = best_vec;
    st_nxt.unack   = best_lvl != 4'h0 && best_lvl <= st_r.cpu_lvl;

    // Processor commands act on what the processor was shown
    if (cpu_cmd.ack && st_r.irq.req) begin
      if (st_r.sp != SPW'(DEPTH)) begin
        st_nxt.stk[st_r.sp] = st_r.cpu_lvl;
        st_nxt.sp           = st_r.sp + SPW'(1);
      end
      st_nxt.cpu_lvl  = st_r.irq.lvl;
      st_nxt.last_vec = st_r.irq.vec;
      evt[`VPIC_EVT_ACK] = 1'b1;
    end else if (cpu_cmd.ret && st_r.sp != '0) begin
      st_nxt.cpu_lvl = st_r.stk[st_r.sp - SPW'(1)];
      st_nxt.sp      = st_r.sp - SPW'(1);
    end else if (cpu_cmd.srl_wr && st_r.cpu_lvl < `VPIC_LVL_TRAP_BASE) begin
      // Status byte writes never lower a trap level
      st_nxt.cpu_lvl = {1'b0, cpu_cmd.srl_data[`VPIC_SRL_LVL_LSB +: 3]};
    end

    // Timed disable countdown
    if (cpu_cmd.timed_interrupt_disable_start) begin
      st_nxt.timed_interrupt_disable = cpu_cmd.timed_interrupt_disable_count;
    end else if (st_r.timed_interrupt_disable != 14'h0000) begin
      st_nxt.timed_interrupt_disable = st_r.timed_interrupt_disable - 14'h0001;
      if (st_r.timed_interrupt_disable == 14'h0001) begin
        evt[`VPIC_EVT_TIMED_INTERRUPT_DISABLE_END] = 1'b1;
      end
    end

    // Bus: no wait state; ready and read data come from flops loaded in the setup cycle
    setup  = apb_req.psel && !apb_req.penable;
    access = apb_req.psel && apb_req.penable && st_r.rsp.pready;
    hit    = mapped(apb_req.paddr);
    case (apb_req.paddr)
      `VPIC_OFF_CTL1:     rword = 16'({st_r.nesting_disable, 15'(st_r.trap)});
      `VPIC_OFF_TEST:     rword = {st_r.unack, 1'b0, st_r.vsel, 1'b0, st_r.cpu_lvl,
                                   1'b0, st_r.vsel ? st_r.irq.vec : st_r.last_vec};
      `VPIC_OFF_FLAGS:    rword = 16'(st_r.flag);
      `VPIC_OFF_ENABLE:   rword = 16'(st_r.en);
      `VPIC_OFF_IRQ_STAT: rword = 16'(st_r.ist);
      `VPIC_OFF_IRQ_MASK: rword = 16'(st_r.imask);
      default: begin
        if (in_prio(apb_req.paddr)) begin
          rword = 16'({st_r.prio[prio_idx(apb_req.paddr)], 4'h0});
        end
      end
    endcase
    st_nxt.rsp.pready  = setup;
    st_nxt.rsp.pslverr = setup && !hit;
    st_nxt.rsp.prdata  = setup ? {16'h0000, rword} : 32'h0000_0000;

    if (access && apb_req.pwrite && hit) begin
      case (apb_req.paddr)
        `VPIC_OFF_CTL1: begin
          st_nxt.nesting_disable = apb_req.pwdata[`VPIC_CTL1_NESTING_DISABLE];
          st_nxt.trap   = st_r.trap & ~apb_req.pwdata[NTRAP-1:0];
        end
        `VPIC_OFF_TEST:     st_nxt.vsel  = apb_req.pwdata[`VPIC_TEST_VSEL];
        `VPIC_OFF_FLAGS:    st_nxt.flag  = st_r.flag & ~apb_req.pwdata[NSRC-1:0];
        `VPIC_OFF_ENABLE:   st_nxt.en    = apb_req.pwdata[NSRC-1:0];
        `VPIC_OFF_IRQ_MASK: st_nxt.imask = apb_req.pwdata[2:0];
        `VPIC_OFF_IRQ_STAT: ;
        default: begin
          st_nxt.prio[prio_idx(apb_req.paddr)] = apb_req.pwdata[`VPIC_PRIO_LSB +: 3];
        end
      endcase
    end
    if (access && !apb_req.pwrite && apb_req.paddr == `VPIC_OFF_IRQ_STAT) begin
      st_nxt.ist = 3'b000;
    end

    // Hardware sets come last so they win over a clear in the same cycle
    st_nxt.flag = st_nxt.flag | src_evt;
    st_nxt.trap = st_nxt.trap | trap_evt;
    evt[`VPIC_EVT_TRAP] = |trap_evt;
    st_nxt.ist     = st_nxt.ist | evt;
    st_nxt.irq_out = |(st_nxt.ist & st_nxt.imask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r      <= '0;
      st_r.prio <= {NSRC{`VPIC_PRIO_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign apb_rsp   = st_r.rsp;
  assign cpu_irq   = st_r.irq;
  assign cpu_level = st_r.cpu_lvl;
  assign irq_o     = st_r.irq_out;

endmodule : vpic_ctrl
`default_nettype wire

// File: verilog/vpic_regs.svh
`ifndef VPIC_REGS_SVH
`define VPIC_REGS_SVH

// Register byte offsets
`define VPIC_OFF_CTL1       12'h000
`define VPIC_OFF_TEST       12'h004
`define VPIC_OFF_FLAGS      12'h008
`define VPIC_OFF_ENABLE     12'h00C
`define VPIC_OFF_IRQ_STAT   12'h010
`define VPIC_OFF_IRQ_MASK   12'h014
`define VPIC_OFF_PRIO_BASE  12'h040

// Priority register layout
`define VPIC_PRIO_LSB       4
`define VPIC_PRIO_RST       3'h4
`define VPIC_PRIO_OFF       3'h0

// Test register layout
`define VPIC_TEST_UNACK     15
`define VPIC_TEST_VSEL      13
`define VPIC_TEST_LVL_LSB   8

// Control register one layout
`define VPIC_CTL1_NESTING_DISABLE    15

// Levels and vectors
`define VPIC_LVL_USER_MAX   4'h7
`define VPIC_LVL_TIMED_INTERRUPT_DISABLE_MAX   4'h6
`define VPIC_LVL_TRAP_BASE  4'h8
`define VPIC_VEC_USER_BASE  7'h08
`define VPIC_SRL_LVL_LSB    1

// Block interrupt status bits
`define VPIC_EVT_ACK        0
`define VPIC_EVT_TRAP       1
`define VPIC_EVT_TIMED_INTERRUPT_DISABLE_END   2

`endif

// File: verilog/vpic_pkg.sv
package vpic_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } vpic_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } vpic_apb_rsp_s;

  typedef struct packed {
    logic        ack;
    logic        ret;
    logic        srl_wr;
    logic [7:0]  srl_data;
    logic        timed_interrupt_disable_start;
    logic [13:0] timed_interrupt_disable_count;
  } vpic_cpu_cmd_s;

  typedef struct packed {
    logic       req;
    logic [3:0] lvl;
    logic [6:0] vec;
  } vpic_cpu_irq_s;

endpackage : vpic_pkg

// File: tb/vpic_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module vpic_ctrl_monitor
  import vpic_pkg::*;
(
  // Clock and reset
  input wire logic          clk,
  input wire logic          rst,
  // Watched ports
  input wire vpic_apb_req_s apb_req,
  input wire vpic_apb_rsp_s apb_rsp,
  input wire vpic_cpu_cmd_s cpu_cmd,
  input wire vpic_cpu_irq_s cpu_irq,
  input wire logic [3:0]    cpu_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup; apb_req.psel && !apb_req.penable; endsequence
  sequence s_take; cpu_cmd.ack && cpu_irq.req; endsequence
  property p_rdy; s_setup |=> apb_rsp.pready; endproperty
  a_rdy: assert property (p_rdy) else $error("late ready");
  property p_hi; apb_rsp.pready |-> apb_rsp.prdata[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper data set");
  // Level changes take a cycle to reach the request
  property p_lvl;
    cpu_irq.req && $stable(cpu_level) && !$past(cpu_cmd.ack) |-> cpu_irq.lvl > cpu_level;
  endproperty
  a_lvl: assert property (p_lvl) else $error("request not above level");
  property p_ack; s_take |=> cpu_level == $past(cpu_irq.lvl); endproperty
  a_ack: assert property (p_ack) else $error("level not taken");
  property p_trap; cpu_irq.req && cpu_irq.lvl[3] |-> cpu_irq.vec == {4'h0, cpu_irq.lvl[2:0]};
  endproperty
  a_trap: assert property (p_trap) else $error("bad trap vector");
  property p_user;
    cpu_irq.req && !cpu_irq.lvl[3] |-> cpu_irq.vec inside {[7'h08:7'h76]} && cpu_irq.lvl != 4'h0;
  endproperty
  a_user: assert property (p_user) else $error("bad user request");
  property p_srl;
    cpu_cmd.srl_wr && !cpu_cmd.ack && !cpu_cmd.ret && !cpu_level[3]
      |=> cpu_level == {1'b0, $past(cpu_cmd.srl_data[3:1])};
  endproperty
  a_srl: assert property (p_srl) else $error("status write lost");
  property p_hold; !cpu_cmd.ack && !cpu_cmd.ret && !cpu_cmd.srl_wr |=> $stable(cpu_level);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved");
endmodule : vpic_ctrl_monitor
bind vpic_ctrl vpic_ctrl_monitor vpic_ctrl_monitor_i (.clk(clk), .rst(rst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .cpu_cmd(cpu_cmd), .cpu_irq(cpu_irq), .cpu_level(cpu_level));
`default_nettype wire

// File: tb/vpic_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module vpic_cpu_model
  import vpic_pkg::*;
(
  // Clock and reset
  input wire logic          clk,
  input wire logic          rst,
  // Controller side
  input wire vpic_cpu_irq_s irq,
  output var vpic_cpu_cmd_s cmd,
  // Bench side
  input wire logic          ack_en,
  input wire vpic_cpu_cmd_s side
);
  logic       ack_r, ret_r;
  logic [3:0] svc_r;
  always_comb begin
    cmd = side;
    cmd.ack = ack_r;
    cmd.ret = ret_r;
  end
  // Slow handler, so a flag left set re-enters
  always_ff @(posedge clk) begin
    ack_r <= 1'b0;
    ret_r <= 1'b0;
    if (rst) svc_r <= 4'h0;
    else if (svc_r != 4'h0) begin
      svc_r <= svc_r - 4'h1;
      ret_r <= svc_r == 4'h1;
    end else if (ack_en && irq.req) begin
      ack_r <= 1'b1;
      svc_r <= 4'h9;
    end
  end
endmodule : vpic_cpu_model
`default_nettype wire

// File: tb/vpic_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module vpic_ctrl_tb;
  import vpic_pkg::*;
  logic clk = 0, rst = 1, irq, ae = 0, ser;
  vpic_apb_req_s q = '0;
  vpic_apb_rsp_s r;
  vpic_cpu_cmd_s sd = '0, cc;
  vpic_cpu_irq_s ci;
  logic [15:0] se = '0;
  logic [3:0] te = '0, lv;
  logic [31:0] d;
  int error_cnt = 0, n_tests = 0, acks = 0;
  initial forever #50 clk = ~clk;
  vpic_ctrl vpic_ctrl_i (.clk(clk), .rst(rst), .apb_req(q), .apb_rsp(r), .src_evt(se),
    .trap_evt(te), .cpu_cmd(cc), .cpu_irq(ci), .cpu_level(lv), .irq_o(irq));
  vpic_cpu_model vpic_cpu_model_i (.clk(clk), .rst(rst), .irq(ci), .cmd(cc), .ack_en(ae),
    .side(sd));
  always @(posedge clk) if (cc.ack && ci.req) acks <= acks + 1;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    q <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clk) q.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!r.pready && n < 20);
    d = r.prdata;
    ser = r.pslverr;
    if (n >= 20) chk(1'b0, 1'b1);
    if (n >= 20) tally_and_finish;
    q <= '0;
    @(posedge clk);
  endtask : xfer
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, '0);
    chk(d, e);
  endtask : rc
  task automatic status_low_byte(input logic [7:0] v);
    sd.srl_wr <= 1'b1;
    sd.srl_data <= v;
    @(posedge clk) sd <= '0;
    @(posedge clk);
  endtask : status_low_byte
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(12'h040, 32'h40);
    rc(12'h07C, 32'h40);
    xfer(1'b1, 12'h040, 32'hFFFF);
    rc(12'h040, 32'h70);
    rc(12'hFF0, 32'h0);
    chk(ser, 1'b1);
    rc(12'h004, 32'h0);
    xfer(1'b1, 12'h00C, 32'h1);
    xfer(1'b1, 12'h014, 32'h1);
    status_low_byte(8'h0E);
    chk(lv, 32'h7);
    se <= 16'h1;
    @(posedge clk) se <= '0;
    repeat (3) @(posedge clk);
    chk(ci.req, 1'b0);
    xfer(1'b1, 12'h004, 32'h2000);
    rc(12'h004, 32'hA708);
    status_low_byte(8'h00);
    sd.timed_interrupt_disable_start <= 1'b1;
    sd.timed_interrupt_disable_count <= 14'd40;
    @(posedge clk) sd <= '0;
    repeat (3) @(posedge clk);
    chk(ci.req, 1'b1);
    xfer(1'b1, 12'h040, 32'h60);
    repeat (2) @(posedge clk);
    chk(ci.req, 1'b0);
    repeat (40) @(posedge clk);
    chk(ci.req, 1'b1);
    ae <= 1'b1;
    repeat (40) @(posedge clk);
    chk(acks > 1, 1'b1);
    ae <= 1'b0;
    xfer(1'b1, 12'h008, 32'h1);
    repeat (12) @(posedge clk);
    chk(irq, 1'b1);
    rc(12'h010, 32'h5);
    rc(12'h010, 32'h0);
    chk(irq, 1'b0);
    status_low_byte(8'h0E);
    te <= 4'h1;
    @(posedge clk) te <= '0;
    repeat (3) @(posedge clk);
    chk({ci.req, ci.lvl, ci.vec}, {1'b1, 4'h8, 7'h00});
    rc(12'h000, 32'h1);
    xfer(1'b1, 12'h000, 32'h8001);
    rc(12'h000, 32'h8000);
    tally_and_finish;
  end
endmodule : vpic_ctrl_tb
`default_nettype wire
